// ==== src/char_fifo.sv ====
`timescale 1ns/10ps
module char_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // extra pointer bit tells full from empty
  assign out_valid = wr_q != rd_q;
  assign in_ready = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
  assign out_data = mem[rd_q[PW-1:0]];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_q[PW-1:0]] <= in_data;
  end
endmodule // char_fifo

// ==== src/serial_cfg_pkg.sv ====
package serial_cfg_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W = 13;
  localparam int unsigned DIV_HI_W = 5;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned IDLE_BITS_SHORT = 10;
  localparam int unsigned IDLE_BITS_LONG = 11;

  localparam logic [ADDR_W-1:0] BAUD_HIGH_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] BAUD_LOW_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] CTRL_ONE_OFS = 3'h2;
  localparam logic [ADDR_W-1:0] CTRL_TWO_OFS = 3'h3;
  localparam logic [ADDR_W-1:0] STATUS_ONE_OFS = 3'h4;
  localparam logic [ADDR_W-1:0] DATA_OFS = 3'h5;
  localparam logic [ADDR_W-1:0] STATUS_TWO_OFS = 3'h6;

  localparam int unsigned BREAK_IE_BIT = 7;
  localparam int unsigned EDGE_IE_BIT = 6;

  localparam logic [DIV_HI_W-1:0] BAUD_HIGH_RST = 5'h00;
  localparam logic [7:0] BAUD_LOW_RST = 8'h04;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_MASK = 8'hce;

  typedef struct packed {
    logic loop_select;
    logic stop_in_wait;
    logic receiver_source;
    logic char_nine;
    logic wake_method;
    logic idle_type;
    logic parity_enable;
    logic parity_type;
  } ctrl_one_t;

  typedef struct packed {
    logic tx_direction;
    logic tx_bit8;
    logic [1:0] unused_hi;
    logic transmitter_enable;
    logic receiver_enable;
    logic rx_wakeup;
    logic unused_lo;
  } ctrl_two_t;

  typedef struct packed {
    logic bit8;
    logic [7:0] data;
  } char_word_t;

  typedef struct packed {
    logic tx_ready;
    logic tx_complete;
    logic rx_full;
    logic idle_seen;
    logic overrun;
    logic frame_err;
    logic parity_err;
    logic unused;
  } status_one_t;
endpackage

// ==== src/serial_port_baud_and_framing_config.sv ====
`timescale 1ns/10ps
module serial_port_baud_and_framing_config
  import serial_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic wait_mode,
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic rx_pin_released,
  output logic irq_req,
  output logic baud_tick
);
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  logic [DIV_HI_W-1:0] div_hi_buf_q;
  logic [DIV_HI_W-1:0] div_hi_q;
  logic [7:0] div_lo_q;
  logic break_ie_q;
  logic edge_ie_q;
  ctrl_one_t c1_q;
  ctrl_two_t c2_q;
  logic armed_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [DATA_W-1:0] rdata_q;

  wire wr_high = wr_en && addr == BAUD_HIGH_OFS;
  wire wr_low = wr_en && addr == BAUD_LOW_OFS;
  wire wr_c1 = wr_en && addr == CTRL_ONE_OFS;
  wire wr_c2 = wr_en && addr == CTRL_TWO_OFS;
  wire wr_st1 = wr_en && addr == STATUS_ONE_OFS;
  wire wr_data = wr_en && addr == DATA_OFS;
  wire wr_st2 = wr_en && addr == STATUS_TWO_OFS;
  wire rd_data = rd_en && addr == DATA_OFS;
  ctrl_two_t c2_wr;
  assign c2_wr = ctrl_two_t'(wdata & CTRL_TWO_MASK);

  // ---------------- baud generator ----------------
  wire [DIV_W-1:0] combined_divisor = {div_hi_q, div_lo_q};
  wire port_running = !(c1_q.stop_in_wait && wait_mode);
  wire baud_run = armed_q && combined_divisor != '0 && port_running;
  wire div_wrap = baud_run && div_cnt_q == combined_divisor - 1'b1;
  wire os_tick = div_wrap;
  wire [DIV_W-1:0] div_cnt_d = (!baud_run || div_wrap) ? '0 : div_cnt_q + 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_hi_buf_q <= BAUD_HIGH_RST;
      div_hi_q <= BAUD_HIGH_RST;
      div_lo_q <= BAUD_LOW_RST;
      break_ie_q <= 1'b0;
      edge_ie_q <= 1'b0;
      c1_q <= ctrl_one_t'(CTRL_ONE_RST);
      armed_q <= 1'b0;
      div_cnt_q <= '0;
    end else begin
      if (wr_high) begin
        div_hi_buf_q <= wdata[DIV_HI_W-1:0];
        break_ie_q <= wdata[BREAK_IE_BIT];
        edge_ie_q <= wdata[EDGE_IE_BIT];
      end
      if (wr_low) begin
        div_lo_q <= wdata;
        div_hi_q <= div_hi_buf_q;
      end
      if (wr_c1) c1_q <= ctrl_one_t'(wdata);
      if (wr_c2 && (c2_wr.transmitter_enable || c2_wr.receiver_enable)) armed_q <= 1'b1;
      div_cnt_q <= div_cnt_d;
    end
  end

  // ---------------- pin synchronisers and routing ----------------
  logic rx_meta_q;
  logic rx_sync_q;
  logic txp_meta_q;
  logic txp_sync_q;
  logic tx_line_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      txp_meta_q <= 1'b1;
      txp_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
      txp_meta_q <= tx_pin_in;
      txp_sync_q <= txp_meta_q;
    end
  end

  wire single_wire = c1_q.loop_select && c1_q.receiver_source;
  // receive pin is only looked at when loop select is clear
  wire loop_src = c1_q.receiver_source ? txp_sync_q : tx_line_q;
  wire rx_in = c1_q.loop_select ? loop_src : rx_sync_q;

  // ---------------- transmit path ----------------
  char_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  tx_state_t tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [3:0] tx_phase_q;

  wire tx_par8 = ^fifo_out.data[6:0] ^ c1_q.parity_type;
  wire tx_par9 = ^fifo_out.data ^ c1_q.parity_type;
  wire [7:0] tx_d8 = c1_q.parity_enable && !c1_q.char_nine ?
                     {tx_par8, fifo_out.data[6:0]} : fifo_out.data;
  wire tx_b9 = c1_q.parity_enable ? tx_par9 : fifo_out.bit8;
  wire [10:0] tx_frame = c1_q.char_nine ? {1'b1, tx_b9, tx_d8, 1'b0} :
                         {2'b11, tx_d8, 1'b0};
  wire tx_load = tx_state_q == TX_IDLE && fifo_out_valid && c2_q.transmitter_enable
                 && os_tick;
  wire tx_bit_end = tx_state_q == TX_SHIFT && os_tick && tx_phase_q == 4'hf;

  char_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(wr_data),
    .in_ready(fifo_in_ready),
    .in_data({c2_q.tx_bit8, wdata}),
    .out_valid(fifo_out_valid),
    .out_ready(tx_load),
    .out_data(fifo_out)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= '1;
      tx_left_q <= '0;
      tx_phase_q <= '0;
      tx_line_q <= 1'b1;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_load) begin
            tx_shift_q <= tx_frame;
            tx_left_q <= c1_q.char_nine ? 4'ha : 4'h9;
            tx_phase_q <= '0;
            tx_line_q <= 1'b0;
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (os_tick) tx_phase_q <= tx_phase_q + 1'b1;
          if (tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_line_q <= tx_shift_q[1];
            tx_left_q <= tx_left_q - 1'b1;
            if (tx_left_q == 4'h0) begin
              tx_line_q <= 1'b1;
              tx_state_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------- receive path ----------------
  rx_state_t rx_state_q;
  logic [3:0] rx_phase_q;
  logic [3:0] rx_cnt_q;
  logic [8:0] rx_shift_q;
  logic rx_prev_q;
  logic [7:0] idle_cnt_q;
  char_word_t rx_data_q;
  logic rdrf_q;
  logic idle_q;
  logic overrun_q;
  logic frame_err_q;
  logic parity_err_q;
  logic break_q;
  logic edge_q;

  wire rx_on = c2_q.receiver_enable && os_tick;
  wire [3:0] rx_last = c1_q.char_nine ? 4'h8 : 4'h7;
  wire rx_done = rx_on && rx_state_q == RX_STOP && rx_phase_q == 4'hf;
  char_word_t rx_word;
  assign rx_word = c1_q.char_nine ? rx_shift_q : {1'b0, rx_shift_q[8:1]};
  wire rx_top = c1_q.char_nine ? rx_word.bit8 : rx_word.data[7];
  wire rx_par_bad = (^rx_word) != c1_q.parity_type;
  wire rx_break = rx_word == '0 && !rx_in;
  wire addr_mark = c1_q.wake_method && rx_top;
  wire rx_accept = (!c2_q.rx_wakeup || addr_mark) && !rx_break;
  wire [7:0] idle_need = 8'(OVERSAMPLE * (c1_q.char_nine ? IDLE_BITS_LONG : IDLE_BITS_SHORT));
  // after-stop counting holds off while a frame is in flight
  wire idle_count_ok = !c1_q.idle_type || rx_state_q == RX_IDLE;
  wire idle_hit = rx_on && rx_in && idle_count_ok && idle_cnt_q == idle_need - 8'h1;
  wire edge_hit = c2_q.receiver_enable && port_running && rx_prev_q && !rx_in;
  wire idle_wake = idle_hit && !c1_q.wake_method;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= '0;
      rx_cnt_q <= '0;
      rx_shift_q <= '0;
    end else if (rx_on) begin
      rx_phase_q <= rx_phase_q + 1'b1;
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_phase_q <= '0;
          if (!rx_in) rx_state_q <= RX_START;
        end
        RX_START: begin
          // realign to the middle of the start bit
          if (rx_phase_q == 4'h7) begin
            rx_phase_q <= '0;
            rx_cnt_q <= '0;
            rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_phase_q == 4'hf) begin
            rx_shift_q <= {rx_in, rx_shift_q[8:1]};
            rx_cnt_q <= rx_cnt_q + 1'b1;
            if (rx_cnt_q == rx_last) rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_phase_q == 4'hf) rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_prev_q <= 1'b1;
      idle_cnt_q <= '0;
      rx_data_q <= '0;
    end else begin
      if (port_running) rx_prev_q <= rx_in;
      if (rx_on) begin
        if (!rx_in || !idle_count_ok) idle_cnt_q <= '0;
        else if (idle_cnt_q != idle_need) idle_cnt_q <= idle_cnt_q + 1'b1;
      end
      if (rx_done && rx_accept && !rdrf_q) rx_data_q <= rx_word;
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdrf_q <= 1'b0;
      idle_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
      parity_err_q <= 1'b0;
      break_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      if (rd_data) rdrf_q <= 1'b0;
      if (rx_done && rx_accept && !rdrf_q) rdrf_q <= 1'b1;
      if (wr_st1 && wdata[4]) idle_q <= 1'b0;
      if (idle_hit && !c2_q.rx_wakeup) idle_q <= 1'b1;
      if (wr_st1 && wdata[3]) overrun_q <= 1'b0;
      if (rx_done && rx_accept && rdrf_q) overrun_q <= 1'b1;
      if (wr_st1 && wdata[2]) frame_err_q <= 1'b0;
      if (rx_done && rx_accept && !rx_in) frame_err_q <= 1'b1;
      if (wr_st1 && wdata[1]) parity_err_q <= 1'b0;
      if (rx_done && rx_accept && c1_q.parity_enable && rx_par_bad) parity_err_q <= 1'b1;
      if (wr_st2 && wdata[7]) break_q <= 1'b0;
      if (rx_done && rx_break) break_q <= 1'b1;
      if (wr_st2 && wdata[6]) edge_q <= 1'b0;
      if (edge_hit) edge_q <= 1'b1;
    end
  end

  // control two: software writes, wakeup bit also cleared by the receiver
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c2_q <= ctrl_two_t'(CTRL_TWO_RST);
    end else begin
      if (wr_c2) c2_q <= c2_wr;
      if ((rx_done && addr_mark) || idle_wake) c2_q.rx_wakeup <= 1'b0;
    end
  end

  // ---------------- register read ----------------
  status_one_t st1;
  assign st1 = '{tx_ready: fifo_in_ready,
                 tx_complete: tx_state_q == TX_IDLE && !fifo_out_valid,
                 rx_full: rdrf_q, idle_seen: idle_q, overrun: overrun_q,
                 frame_err: frame_err_q, parity_err: parity_err_q, unused: 1'b0};
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (addr)
      BAUD_HIGH_OFS: rd_mux = {break_ie_q, edge_ie_q, 1'b0, div_hi_buf_q};
      BAUD_LOW_OFS: rd_mux = div_lo_q;
      CTRL_ONE_OFS: rd_mux = c1_q;
      CTRL_TWO_OFS: rd_mux = c2_q;
      STATUS_ONE_OFS: rd_mux = st1;
      DATA_OFS: rd_mux = rx_data_q.data;
      STATUS_TWO_OFS: rd_mux = {break_q, edge_q, 5'h00, rx_data_q.bit8};
      default: rd_mux = '0;
    endcase
  end

  // ---------------- registered outputs ----------------
  logic tx_oe_q;
  logic rx_rel_q;
  logic irq_q;
  logic tick_q;
  wire tx_busy = tx_state_q == TX_SHIFT;
  // single wire: drive needs the direction bit set and the transmitter enabled or busy
  wire tx_oe_d = (c2_q.transmitter_enable || tx_busy) &&
                 (!single_wire || c2_q.tx_direction);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
      tx_oe_q <= 1'b0;
      rx_rel_q <= 1'b1;
      irq_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      rdata_q <= rd_en ? rd_mux : '0;
      tx_oe_q <= tx_oe_d;
      rx_rel_q <= c1_q.loop_select || !c2_q.receiver_enable;
      irq_q <= (break_q && break_ie_q) || (edge_q && edge_ie_q);
      tick_q <= os_tick;
    end
  end

  assign rdata = rdata_q;
  assign tx_pin_out = tx_line_q;
  assign tx_pin_oe = tx_oe_q;
  assign rx_pin_released = rx_rel_q;
  assign irq_req = irq_q;
  assign baud_tick = tick_q;
endmodule // serial_port_baud_and_framing_config

// ==== tb/remote_node.sv ====
`timescale 1ns/10ps
module remote_node #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic tx
);
  logic [8:0] got;
  initial tx = 1'b1;
  // samples mid-bit, least significant bit first
  task automatic recv(input int nb);
    int k;
    @(posedge clk);
    got = 9'h000;
    while (line !== 1'b0) @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (k = 0; k < nb; k++) begin
      repeat (BIT_CLKS) @(posedge clk);
      got[k] = line;
    end
    // run on to mid stop bit, else a low last data bit looks like the next start
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  task automatic send(input logic [8:0] c, input int nb, input logic stop);
    int k;
    @(posedge clk);
    tx <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (k = 0; k < nb; k++) begin
      tx <= c[k];
      repeat (BIT_CLKS) @(posedge clk);
    end
    tx <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    tx <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask
endmodule // remote_node

// ==== tb/serial_cfg_sva.sv ====
`timescale 1ns/10ps
module serial_cfg_sva
  import serial_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic wait_mode,
  input wire logic rx_pin_released,
  input wire logic irq_req,
  input wire logic baud_tick
);
  logic [7:0] hb_q, lo_q, c1_q;
  logic [4:0] hw_q;
  logic [13:0] gap_q;
  logic [1:0] seen_q;
  logic on_q, rxe_q;
  wire [12:0] div = {hw_q, lo_q};
  wire wr_lo = wr_en && addr == BAUD_LOW_OFS;
  wire wr_c2 = wr_en && addr == CTRL_TWO_OFS;
  // the first tick after a reload may land early, so two ticks pass before judging
  wire stall = wr_lo || (wait_mode && c1_q[6]) || div == 13'h0000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hb_q <= 8'h00;
      hw_q <= 5'h00;
      lo_q <= BAUD_LOW_RST;
      c1_q <= 8'h00;
      on_q <= 1'b0;
      rxe_q <= 1'b0;
      seen_q <= 2'h0;
    end else begin
      if (wr_en && addr == BAUD_HIGH_OFS) hb_q <= wdata;
      if (wr_lo) hw_q <= hb_q[4:0];
      if (wr_lo) lo_q <= wdata;
      if (wr_en && addr == CTRL_ONE_OFS) c1_q <= wdata;
      if (wr_c2) rxe_q <= wdata[2];
      if (wr_c2 && wdata[3:2] != 2'b00) on_q <= 1'b1;
      if (stall) seen_q <= 2'h0;
      else if (baud_tick && seen_q != 2'h2) seen_q <= seen_q + 2'h1;
    end
    gap_q <= baud_tick ? 14'h0001 : gap_q + 14'h0001;
  end
  property p_idle_until_enable; !on_q |-> !baud_tick; endproperty
  a_idle_until_enable: assert property (p_idle_until_enable)
    else $error("baud tick before any enable");
  property p_zero_stops; div == 13'h0000 && $past(div) == 13'h0000 |-> !baud_tick; endproperty
  a_zero_stops: assert property (p_zero_stops)
    else $error("baud tick with zero divisor");
  property p_tick_period; baud_tick && seen_q == 2'h2 |-> gap_q == {1'b0, div}; endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing differs from divisor");
  property p_wait_freeze; (wait_mode && c1_q[6]) [*3] |-> !baud_tick; endproperty
  a_wait_freeze: assert property (p_wait_freeze)
    else $error("baud tick while frozen in wait");
  property p_high_readback;
    $past(rd_en) && $past(addr) == BAUD_HIGH_OFS
      |-> {rdata[7:6], rdata[4:0]} == $past({hb_q[7:6], hb_q[4:0]});
  endproperty
  a_high_readback: assert property (p_high_readback)
    else $error("high divisor readback wrong");
  property p_low_readback; $past(rd_en) && $past(addr) == BAUD_LOW_OFS |-> rdata == $past(lo_q);
  endproperty
  a_low_readback: assert property (p_low_readback)
    else $error("low divisor readback wrong");
  property p_pin_release;
    $stable(c1_q[7]) && $stable(rxe_q) |-> rx_pin_released == (c1_q[7] || !rxe_q);
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("receive pin release wrong");
  property p_irq_gated; hb_q[7:6] == 2'b00 && $past(hb_q[7:6]) == 2'b00 |-> !irq_req; endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("request with both enables clear");
endmodule // serial_cfg_sva
bind serial_port_baud_and_framing_config serial_cfg_sva u_serial_cfg_sva (.clk(clk),
  .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .wait_mode(wait_mode), .rx_pin_released(rx_pin_released), .irq_req(irq_req),
  .baud_tick(baud_tick));

// ==== tb/test_serial_port_baud_and_framing_config.sv ====
`timescale 1ns/10ps
module test_serial_port_baud_and_framing_config
  import serial_cfg_pkg::*;
;
  logic clk, rst_b, wr_en, rd_en, wait_mode, divert, rtx;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic tx_pin_out, tx_pin_oe, rx_pin_released, irq_req, baud_tick;
  int error_cnt, comparisons, n, i;
  // a pin nobody listens to carries the inverse, so wrong routing corrupts data
  wire line = tx_pin_oe ? tx_pin_out : (divert ? rtx : 1'b1);
  wire rx_pin = divert ? ~rtx : rtx;
  logic [36:0] frm [5] = '{{8'h00, 8'h08, 8'h55, 4'h8, 9'h055},
    {8'h03, 8'h08, 8'h03, 4'h8, 9'h083}, {8'h02, 8'h08, 8'h07, 4'h8, 9'h087},
    {8'h10, 8'h48, 8'ha5, 4'h9, 9'h1a5}, {8'h12, 8'h08, 8'h01, 4'h9, 9'h101}};
  serial_port_baud_and_framing_config u_serial_port_baud_and_framing_config (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .wait_mode(wait_mode), .rx_pin(rx_pin), .tx_pin_in(line),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_released(rx_pin_released),
    .irq_req(irq_req), .baud_tick(baud_tick));
  remote_node u_remote_node (.clk(clk), .line(line), .tx(rtx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic ticks(input int c);
    n = 0;
    repeat (c) begin
      @(negedge clk);
      if (baud_tick === 1'b1) n++;
    end
  endtask
  task automatic t_reset;
    chk({tx_pin_out, tx_pin_oe, rx_pin_released, irq_req}, 4'ha);
    rd(BAUD_HIGH_OFS);
    chk(d, 8'h00);
    rd(BAUD_LOW_OFS);
    chk(d, BAUD_LOW_RST);
    rd(CTRL_ONE_OFS);
    chk(d, 8'h00);
    rd(3'h7);
    chk(d, 8'h00);
    ticks(100);
    chk(n, 0);
  endtask
  task automatic t_divisor;
    wr(CTRL_TWO_OFS, 8'h08);
    ticks(20);
    ticks(40);
    chk(n, 10);
    wr(BAUD_HIGH_OFS, 8'h01);
    rd(BAUD_HIGH_OFS);
    chk(d, 8'h01);
    ticks(40);
    chk(n, 10);
    wr(BAUD_LOW_OFS, 8'h02);
    ticks(300);
    ticks(516);
    chk(n, 2);
    wr(BAUD_HIGH_OFS, 8'h00);
    wr(BAUD_LOW_OFS, 8'h00);
    settle;
    ticks(100);
    chk(n, 0);
  endtask
  task automatic t_fifo;
    // generator stopped, so nothing drains while the buffer fills
    for (i = 0; i < 9; i++) wr(DATA_OFS, 8'h30 + i[7:0]);
    rd(STATUS_ONE_OFS);
    chk(d[7], 1'b0);
    wr(BAUD_LOW_OFS, 8'h01);
    for (i = 0; i < 8; i++) begin
      u_remote_node.recv(8);
      chk(u_remote_node.got, 9'h030 + i[8:0]);
    end
    rd(STATUS_ONE_OFS);
    chk(d[7], 1'b1);
  endtask
  task automatic t_frames;
    for (i = 0; i < 5; i++) begin
      wr(CTRL_ONE_OFS, frm[i][36:29]);
      wr(CTRL_TWO_OFS, frm[i][28:21]);
      fork
        u_remote_node.recv(frm[i][12:9]);
        wr(DATA_OFS, frm[i][20:13]);
      join
      chk(u_remote_node.got, frm[i][8:0]);
      repeat (32) @(posedge clk);
    end
  endtask
  task automatic t_rx;
    wr(CTRL_ONE_OFS, 8'h20);
    wr(CTRL_TWO_OFS, 8'h0c);
    settle;
    chk(rx_pin_released, 1'b0);
    u_remote_node.send(9'h03c, 8, 1'b1);
    rd(DATA_OFS);
    chk(d, 8'h3c);
    wr(CTRL_ONE_OFS, 8'h02);
    u_remote_node.send(9'h001, 8, 1'b1);
    rd(STATUS_ONE_OFS);
    chk(d[1], 1'b1);
    rd(DATA_OFS);
    wr(STATUS_ONE_OFS, 8'h1e);
  endtask
  task automatic t_loop;
    wr(CTRL_ONE_OFS, 8'h80);
    divert <= 1'b1;
    settle;
    chk(rx_pin_released, 1'b1);
    fork
      u_remote_node.recv(8);
      wr(DATA_OFS, 8'h5a);
    join
    repeat (32) @(posedge clk);
    rd(DATA_OFS);
    chk(d, 8'h5a);
  endtask
  task automatic t_single;
    wr(CTRL_ONE_OFS, 8'ha0);
    wr(CTRL_TWO_OFS, 8'h04);
    settle;
    chk(tx_pin_oe, 1'b0);
    u_remote_node.send(9'h069, 8, 1'b1);
    rd(DATA_OFS);
    chk(d, 8'h69);
    wr(CTRL_TWO_OFS, 8'h8c);
    settle;
    chk(tx_pin_oe, 1'b1);
    @(posedge clk);
    divert <= 1'b0;
    wr(CTRL_ONE_OFS, 8'h00);
  endtask
  task automatic t_irq;
    wr(STATUS_TWO_OFS, 8'hc0);
    wr(BAUD_HIGH_OFS, 8'h40);
    settle;
    chk(irq_req, 1'b0);
    u_remote_node.send(9'h0f0, 8, 1'b1);
    chk(irq_req, 1'b1);
    wr(BAUD_HIGH_OFS, 8'h00);
    settle;
    chk(irq_req, 1'b0);
    rd(STATUS_TWO_OFS);
    chk(d[7:6], 2'b01);
    wr(BAUD_HIGH_OFS, 8'h80);
    u_remote_node.send(9'h000, 8, 1'b0);
    chk(irq_req, 1'b1);
    wr(STATUS_TWO_OFS, 8'hc0);
    settle;
    chk(irq_req, 1'b0);
  endtask
  task automatic t_wait;
    wr(CTRL_ONE_OFS, 8'h40);
    wait_mode <= 1'b1;
    ticks(8);
    ticks(50);
    chk(n, 0);
    @(posedge clk);
    wait_mode <= 1'b0;
    wr(CTRL_ONE_OFS, 8'h00);
    wait_mode <= 1'b1;
    ticks(8);
    ticks(48);
    chk(n, 48);
    @(posedge clk);
    wait_mode <= 1'b0;
  endtask
  task automatic t_wake;
    // let any frame left over from the break test run out first
    repeat (320) @(posedge clk);
    rd(DATA_OFS);
    wr(STATUS_ONE_OFS, 8'h1e);
    u_remote_node.send(9'h0ff, 8, 1'b1);
    rd(STATUS_ONE_OFS);
    chk(d[4], 1'b1);
    wr(CTRL_ONE_OFS, 8'h04);
    wr(STATUS_ONE_OFS, 8'h10);
    u_remote_node.send(9'h0ff, 8, 1'b1);
    rd(STATUS_ONE_OFS);
    chk(d[4], 1'b0);
    rd(DATA_OFS);
    wr(CTRL_ONE_OFS, 8'h08);
    wr(CTRL_TWO_OFS, 8'h0e);
    u_remote_node.send(9'h012, 8, 1'b1);
    rd(STATUS_ONE_OFS);
    chk(d[5], 1'b0);
    u_remote_node.send(9'h0a5, 8, 1'b1);
    rd(CTRL_TWO_OFS);
    chk(d[1], 1'b0);
    rd(DATA_OFS);
    chk(d, 8'ha5);
  endtask
  initial begin
    error_cnt = 0;
    comparisons = 0;
    {rst_b, wr_en, rd_en, wait_mode, divert} = 5'h00;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_divisor;
    t_fifo;
    t_frames;
    t_rx;
    t_loop;
    t_single;
    t_irq;
    t_wait;
    t_wake;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
endmodule // test_serial_port_baud_and_framing_config
